//--- logic/dapg_pkg.sv
/*
 package for the dual auxiliary pulse generator: register map, field
 positions, reset values and the bus response codes.
 assumes: AXI4-Lite slave with 32-bit data, one clock aclk.
*/
package dapg_pkg;

   // -------------------------------------------------------------
   // register byte addresses
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_PERIOD_ZERO = 8'h00;
   localparam logic [7:0] ADDR_PERIOD_ONE  = 8'h04;
   localparam logic [7:0] ADDR_ONTIME_ZERO = 8'h08;
   localparam logic [7:0] ADDR_ONTIME_ONE  = 8'h0C;
   localparam logic [7:0] ADDR_MODE_CTRL   = 8'h10;
   localparam logic [7:0] ADDR_PIN_SELECT  = 8'h14;
   localparam logic [7:0] ADDR_UPPER_IO    = 8'h18;
   localparam logic [7:0] ADDR_STATUS      = 8'h1C;

   // -------------------------------------------------------------
   // fields and reset values
   // -------------------------------------------------------------
   localparam int         MODE_INDEP_BIT   = 8;
   localparam int         SEL_SECOND_BIT   = 7;
   localparam int         SEL_FIRST_BIT    = 1;
   localparam int         GPIO_DATA_BIT    = 0;
   localparam logic [7:0] PERIOD_RST       = 8'hFF;
   localparam logic [7:0] ONTIME_RST       = 8'h00;
   localparam logic [8:0] MODE_RST         = 9'h000;
   localparam logic [7:0] PIN_SEL_RST      = 8'hFF;
   localparam logic [1:0] UPPER_IO_RST     = 2'h2;
   localparam int         TICK_DIV         = 2;

   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_SLVERR      = 2'h2;

   // one generator's settings as fed to its channel; only on-time is latched per cycle
   typedef struct packed {
      logic [7:0] period;
      logic [7:0] on_time;
   } dapg_chan_cfg_t;

endpackage

//--- logic/dapg_channel.sv
/*
 one pulse channel: an 8-bit tick counter with a latched on-time.
 assumes: tick_en is a one-cycle enable every two aclk cycles; restart
 is a one-cycle pulse from the register file.
*/
module dapg_channel (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        tick_en,
   input  wire logic        restart,
   input  wire logic        start_ok,
   input  wire logic [7:0]  period,
   input  wire logic [7:0]  on_time,
   output logic             pulse_ff,
   output logic             wrap,
   output logic             running_ff
);

   // -------------------------------------------------------------
   // counter and on-time latch
   // -------------------------------------------------------------
   logic [7:0] count_ff;
   logic [7:0] on_lat_ff;
   logic [7:0] nxt_count;
   logic [7:0] nxt_on;
   logic       nxt_pulse;
   logic       at_end;
   logic       cyc_start;

   assign at_end    = running_ff && (count_ff == period);
   assign wrap      = tick_en && at_end;
   // a channel held back by start_ok begins its first cycle once released
   assign cyc_start = tick_en && (at_end || (!running_ff && start_ok));
   assign nxt_count = (!running_ff || at_end) ? 8'h00 : 8'(count_ff + 8'h01); // [RQ2]
   // on-time sampled only as a cycle begins
   assign nxt_on    = cyc_start ? on_time : on_lat_ff;                       // [RQ10]
   // high while ticks into the cycle are below on-time; over-range gives 100%
   assign nxt_pulse = (nxt_count < nxt_on) || (nxt_on > period);         // [RQ4] [RQ5] [RQ6] [RQ18]

   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin                                       // [RQ11]
         count_ff   <= 8'h00;
         on_lat_ff  <= dapg_pkg::ONTIME_RST;
         pulse_ff   <= 1'b0;
         running_ff <= 1'b0;
      end else if (cyc_start || (tick_en && running_ff)) begin
         count_ff   <= nxt_count;
         on_lat_ff  <= nxt_on;
         pulse_ff   <= nxt_pulse;
         running_ff <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   // judged on the latched on-time, which is what the running cycle uses
   AST_ZERO_DUTY: assert property (@(posedge aclk) disable iff (!aresetn)         // [RQ5]
      on_lat_ff == 8'h00 |-> !pulse_ff)
      else $error("zero on-time produced a pulse");
   AST_FULL_DUTY: assert property (@(posedge aclk) disable iff (!aresetn || restart) // [RQ6]
      tick_en && (cyc_start || running_ff) && (nxt_on > period) |=> pulse_ff)
      else $error("over-range on-time not full duty");

endmodule

//--- logic/dapg_top.sv
/*
 dual auxiliary pulse generator with AXI4-Lite register access and
 shared pin multiplexing toward general-purpose lines.
 assumes: a single 10 MHz clock; the general-purpose side drives the
 gpio_* inputs from logic in the same clock domain.
*/
// Function
// [RQ1] mode bit set selects independent mode
// [RQ2] tick is two clocks, period value plus one
// [RQ3] independent: each period register own output
// [RQ4] on-time equals value times tick
// [RQ5] duty from zero to hundred percent
// [RQ6] on-time above period gives full duty
// [RQ7] mode bit clear: shared first period
// [RQ8] offset mode delays second rising edge
// [RQ9] software keeps offset below first period
// [RQ10] new on-time used at next cycle
// [RQ11] period write restarts both timers
// [RQ12] mode bit cleared after reset
// [RQ13] period registers reset to all ones
// [RQ14] on-time registers reset to zero
// [RQ15] second pin select bit picks function
// [RQ16] upper io bit one picks first pin
// [RQ17] pin selects set after reset
// [RQ18] output high for on-time then low
module dapg_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        gpio_line_seven,
   input  wire logic        gpio_line_eight,
   output logic             pin_second,
   output logic             pin_first,
   output logic             pulse_out_first,
   output logic             pulse_out_second
);

   // -------------------------------------------------------------
   // register storage
   // -------------------------------------------------------------
   logic [7:0] aux_period_zero_ff;
   logic [7:0] aux_period_or_offset_one_ff;
   logic [7:0] aux_on_time_zero_ff;
   logic [7:0] aux_on_time_one_ff;
   logic [8:0] mode_control_register_ff;
   logic [7:0] pin_function_select_ff;
   logic [1:0] upper_io_data_register_ff;

   // -------------------------------------------------------------
   // write channel: address and data taken in either order
   // -------------------------------------------------------------
   logic        aw_held_ff;
   logic        w_held_ff;
   logic [7:0]  aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0]  w_strb_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        wr_go;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_hit;
   logic        wr_lane0;
   logic        wr_lane1;

   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready  = !w_held_ff && !bvalid_ff;
   assign wr_addr  = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
   assign wr_data  = w_held_ff ? w_data_ff : s_axi_wdata;
   assign wr_strb  = w_held_ff ? w_strb_ff : s_axi_wstrb;
   assign wr_go    = !bvalid_ff
                     && (aw_held_ff || s_axi_awvalid)
                     && (w_held_ff || s_axi_wvalid);
   assign wr_lane0 = wr_go && wr_strb[0];
   assign wr_lane1 = wr_go && wr_strb[1];

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == dapg_pkg::ADDR_PERIOD_ZERO) || (a == dapg_pkg::ADDR_PERIOD_ONE)
               || (a == dapg_pkg::ADDR_ONTIME_ZERO) || (a == dapg_pkg::ADDR_ONTIME_ONE)
               || (a == dapg_pkg::ADDR_MODE_CTRL)   || (a == dapg_pkg::ADDR_PIN_SELECT)
               || (a == dapg_pkg::ADDR_UPPER_IO)    || (a == dapg_pkg::ADDR_STATUS);
   endfunction

   assign wr_hit = is_mapped(wr_addr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff  <= 32'h0000_0000;
         w_strb_ff  <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= dapg_pkg::RESP_OKAY;
      end else begin
         if (wr_go) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= wr_hit ? dapg_pkg::RESP_OKAY : dapg_pkg::RESP_SLVERR;
         end else begin
            if (s_axi_awvalid && s_axi_awready) begin
               aw_held_ff <= 1'b1;
               aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               w_held_ff <= 1'b1;
               w_data_ff <= s_axi_wdata;
               w_strb_ff <= s_axi_wstrb;
            end
            if (bvalid_ff && s_axi_bready) begin
               bvalid_ff <= 1'b0;
            end
         end
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp  = bresp_ff;

   // -------------------------------------------------------------
   // register writes
   // -------------------------------------------------------------
   logic we_per0;
   logic we_per1;
   logic we_on0;
   logic we_on1;
   logic we_mode_lo;
   logic we_mode_hi;
   logic we_sel;
   logic we_uio;
   logic period_restart;

   assign we_per0    = wr_lane0 && (wr_addr == dapg_pkg::ADDR_PERIOD_ZERO);
   assign we_per1    = wr_lane0 && (wr_addr == dapg_pkg::ADDR_PERIOD_ONE);
   assign we_on0     = wr_lane0 && (wr_addr == dapg_pkg::ADDR_ONTIME_ZERO);
   assign we_on1     = wr_lane0 && (wr_addr == dapg_pkg::ADDR_ONTIME_ONE);
   assign we_mode_lo = wr_lane0 && (wr_addr == dapg_pkg::ADDR_MODE_CTRL);
   assign we_mode_hi = wr_lane1 && (wr_addr == dapg_pkg::ADDR_MODE_CTRL);
   assign we_sel     = wr_lane0 && (wr_addr == dapg_pkg::ADDR_PIN_SELECT);
   assign we_uio     = wr_lane0 && (wr_addr == dapg_pkg::ADDR_UPPER_IO);
   // restart is registered so the counters see the new period value
   logic restart_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_period_zero_ff          <= dapg_pkg::PERIOD_RST;       // [RQ13]
         aux_period_or_offset_one_ff <= dapg_pkg::PERIOD_RST;       // [RQ13]
         aux_on_time_zero_ff         <= dapg_pkg::ONTIME_RST;       // [RQ14]
         aux_on_time_one_ff          <= dapg_pkg::ONTIME_RST;       // [RQ14]
         mode_control_register_ff    <= dapg_pkg::MODE_RST;         // [RQ12]
         pin_function_select_ff      <= dapg_pkg::PIN_SEL_RST;      // [RQ17]
         upper_io_data_register_ff   <= dapg_pkg::UPPER_IO_RST;     // [RQ17]
         restart_ff                  <= 1'b0;
      end else begin
         if (we_per0) aux_period_zero_ff <= wr_data[7:0];
         if (we_per1) aux_period_or_offset_one_ff <= wr_data[7:0];
         if (we_on0) aux_on_time_zero_ff <= wr_data[7:0];
         if (we_on1) aux_on_time_one_ff <= wr_data[7:0];
         if (we_mode_lo) mode_control_register_ff[7:0] <= wr_data[7:0];
         if (we_mode_hi) mode_control_register_ff[8] <= wr_data[8];
         if (we_sel) pin_function_select_ff <= wr_data[7:0];
         if (we_uio) upper_io_data_register_ff <= wr_data[1:0];
         restart_ff <= we_per0 || we_per1;                           // [RQ11]
      end
   end
   assign period_restart = restart_ff;

   // -------------------------------------------------------------
   // timebase: one tick every two clocks
   // -------------------------------------------------------------
   logic [1:0] div_ff;
   logic       tick_en;

   assign tick_en = (div_ff == 2'(dapg_pkg::TICK_DIV - 1));            // [RQ2]
   always_ff @(posedge aclk) begin
      if (!aresetn || period_restart) begin
         div_ff <= 2'h0;
      end else begin
         div_ff <= tick_en ? 2'h0 : 2'(div_ff + 2'h1);
      end
   end

   // -------------------------------------------------------------
   // generators and offset delay
   // -------------------------------------------------------------
   logic                     indep_mode;
   dapg_pkg::dapg_chan_cfg_t cfg_one;
   logic [7:0]               off_cnt_ff;
   logic                     off_busy_ff;
   logic                     off_done;
   logic                     wrap_first;
   logic                     run_first;
   logic                     run_second;
   logic                     start_second;
   logic                     first_rise;
   logic                     pulse_first_ff;
   logic                     pulse_second_ff;

   assign indep_mode     = mode_control_register_ff[dapg_pkg::MODE_INDEP_BIT]; // [RQ1] [RQ7]
   assign cfg_one.period = indep_mode ? aux_period_or_offset_one_ff
                                      : aux_period_zero_ff;                 // [RQ3] [RQ7]
   assign cfg_one.on_time = aux_on_time_one_ff;
   // first output starts a cycle on a fresh start or a wrap
   assign first_rise     = tick_en && (wrap_first || !run_first);
   assign off_done       = tick_en && off_busy_ff && (off_cnt_ff == aux_period_or_offset_one_ff);
   assign start_second   = indep_mode || off_done;

   // in offset mode the second channel is started once, after the delay,
   // then runs on the shared period so the offset stays fixed
   always_ff @(posedge aclk) begin
      if (!aresetn || period_restart || indep_mode) begin
         off_cnt_ff  <= 8'h00;
         off_busy_ff <= 1'b0;
      end else if (first_rise && !run_second) begin
         off_cnt_ff  <= 8'h00;
         off_busy_ff <= 1'b1;
      end else if (off_done) begin
         off_busy_ff <= 1'b0;                                               // [RQ8]
      end else if (tick_en && off_busy_ff) begin
         off_cnt_ff  <= 8'(off_cnt_ff + 8'h01);
      end
   end

   dapg_channel u_first (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .tick_en    (tick_en),
      .restart    (period_restart),
      .start_ok   (1'b1),
      .period     (aux_period_zero_ff),
      .on_time    (aux_on_time_zero_ff),
      .pulse_ff   (pulse_first_ff),
      .wrap       (wrap_first),
      .running_ff (run_first)
   );

   dapg_channel u_second (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .tick_en    (tick_en),
      .restart    (period_restart),
      .start_ok   (start_second),
      .period     (cfg_one.period),
      .on_time    (cfg_one.on_time),
      .pulse_ff   (pulse_second_ff),
      .wrap       (),
      .running_ff (run_second)
   );

   // -------------------------------------------------------------
   // pin multiplexing
   // -------------------------------------------------------------
   logic sel_gpio_second;
   logic sel_gpio_first;

   assign sel_gpio_second  = pin_function_select_ff[dapg_pkg::SEL_SECOND_BIT];
   assign sel_gpio_first   = upper_io_data_register_ff[dapg_pkg::SEL_FIRST_BIT];
   assign pulse_out_first  = pulse_first_ff;
   assign pulse_out_second = pulse_second_ff;
   assign pin_second = sel_gpio_second ? gpio_line_seven : pulse_second_ff;  // [RQ15]
   assign pin_first  = sel_gpio_first  ? gpio_line_eight : pulse_first_ff;   // [RQ16]

   // -------------------------------------------------------------
   // read channel
   // -------------------------------------------------------------
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic [31:0] rd_word;
   logic        rd_go;

   assign s_axi_arready = !rvalid_ff;
   assign rd_go         = s_axi_arvalid && !rvalid_ff;
   assign rd_word =
      (s_axi_araddr == dapg_pkg::ADDR_PERIOD_ZERO) ? {24'h00_0000, aux_period_zero_ff} :
      (s_axi_araddr == dapg_pkg::ADDR_PERIOD_ONE)  ? {24'h00_0000, aux_period_or_offset_one_ff} :
      (s_axi_araddr == dapg_pkg::ADDR_ONTIME_ZERO) ? {24'h00_0000, aux_on_time_zero_ff} :
      (s_axi_araddr == dapg_pkg::ADDR_ONTIME_ONE)  ? {24'h00_0000, aux_on_time_one_ff} :
      (s_axi_araddr == dapg_pkg::ADDR_MODE_CTRL)   ? {23'h00_0000, mode_control_register_ff} :
      (s_axi_araddr == dapg_pkg::ADDR_PIN_SELECT)  ? {24'h00_0000, pin_function_select_ff} :
      (s_axi_araddr == dapg_pkg::ADDR_UPPER_IO)    ? {30'h0000_0000, upper_io_data_register_ff} :
      (s_axi_araddr == dapg_pkg::ADDR_STATUS)      ?
         {28'h000_0000, run_second, run_first, pulse_second_ff, pulse_first_ff} :
      32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= dapg_pkg::RESP_OKAY;
      end else if (rd_go) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rd_word;
         rresp_ff  <= is_mapped(s_axi_araddr) ? dapg_pkg::RESP_OKAY : dapg_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata  = rdata_ff;
   assign s_axi_rresp  = rresp_ff;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   AST_RESET_MODE: assert property (@(posedge aclk) $rose(aresetn) |->   // [RQ12]
      !indep_mode) else $error("mode bit not clear after reset");
   AST_RESET_PERIOD: assert property (@(posedge aclk) $rose(aresetn) |-> // [RQ13]
      aux_period_zero_ff == dapg_pkg::PERIOD_RST
      && aux_period_or_offset_one_ff == dapg_pkg::PERIOD_RST)
      else $error("period registers not all ones after reset");
   AST_RESET_ONTIME: assert property (@(posedge aclk) $rose(aresetn) |-> // [RQ14]
      aux_on_time_zero_ff == 8'h00 && aux_on_time_one_ff == 8'h00)
      else $error("on-time registers not zero after reset");
   AST_RESET_PINSEL: assert property (@(posedge aclk) $rose(aresetn) |-> // [RQ17]
      sel_gpio_first && sel_gpio_second) else $error("pins not gpio after reset");
   AST_RESTART: assert property (@(posedge aclk) disable iff (!aresetn)  // [RQ11]
      we_per0 |=> ##1 !run_first && !pulse_first_ff)
      else $error("period write did not restart timer");
   AST_PIN_FIRST: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ16]
      !sel_gpio_first |-> pin_first == pulse_first_ff)
      else $error("first pin not carrying pulse");
   AST_INDEP_START: assert property (@(posedge aclk) disable iff (!aresetn || period_restart) // [RQ1]
      indep_mode && tick_en && !run_second |=> run_second)
      else $error("second channel not started in independent mode");
   AST_TICK_RATE: assert property (@(posedge aclk) disable iff (!aresetn || period_restart) // [RQ2]
      tick_en |=> !tick_en) else $error("tick faster than two clocks");
   AST_PIN_SECOND: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ15]
      !sel_gpio_second |-> pin_second == pulse_second_ff)
      else $error("second pin not carrying pulse");

endmodule

//--- bench/dapg_load_model.sv
/*
 load model at the pulse side, standing for a switch or filter input:
 measures high time, period and rise-to-rise gap in aclk cycles.
 assumes: both pulses are synchronous to aclk.
*/
module dapg_load_model (
   input  wire logic        aclk,
   input  wire logic        pulse_a,
   input  wire logic        pulse_b,
   output logic [31:0]      hi_a,
   output logic [31:0]      per_a,
   output logic [31:0]      hi_b,
   output logic [31:0]      per_b,
   output logic [31:0]      gap
);
   timeunit 1ns;
   timeprecision 1ns;

   logic        q_a = 1'b0;
   logic        q_b = 1'b0;
   logic [31:0] cnt_a = '0;
   logic [31:0] cnt_b = '0;
   logic [31:0] cnt_g = '0;

   // -------------------------------------------------------------
   // edge timing
   // -------------------------------------------------------------
   // a pulse stuck high or low leaves the last figures in place
   always @(posedge aclk) begin
      q_a <= pulse_a;
      q_b <= pulse_b;
      cnt_a <= (pulse_a && !q_a) ? 32'h0000_0001 : cnt_a + 32'h0000_0001;
      cnt_b <= (pulse_b && !q_b) ? 32'h0000_0001 : cnt_b + 32'h0000_0001;
      cnt_g <= (pulse_a && !q_a) ? 32'h0000_0001 : cnt_g + 32'h0000_0001;
      if (pulse_a && !q_a) per_a <= cnt_a;
      if (!pulse_a && q_a) hi_a <= cnt_a;
      if (pulse_b && !q_b) per_b <= cnt_b;
      if (!pulse_b && q_b) hi_b <= cnt_b;
      if (pulse_b && !q_b) gap <= cnt_g;
   end
endmodule

//--- bench/dual_aux_pwm_generator_bench.sv
/*
 bench for dapg_top: axi4-lite master tasks and waveform checks.
 assumes: dapg_load_model measures the raw pulse outputs.
*/
module dual_aux_pwm_generator_bench;
   timeunit 1ns;
   timeprecision 1ns;

   logic        aclk, aresetn;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] wdata, rdata, rd, per0, hi0, per1, hi1, gap;
   logic [3:0]  wstrb;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rs, br;
   logic        g7, g8, pin_s, pin_f, p0, p1;
   int          n_mismatch = 0;
   int          n_tests = 0;
   logic [31:0] rst_tab [8] = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_0000,
                                32'h0000_0000, 32'h0000_0000, 32'h0000_00FF,
                                32'h0000_0002, 32'h0000_0004};

   dapg_top u_dapg_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .gpio_line_seven(g7), .gpio_line_eight(g8),
      .pin_second(pin_s), .pin_first(pin_f), .pulse_out_first(p0),
      .pulse_out_second(p1));

   dapg_load_model u_dapg_load_model (.aclk(aclk), .pulse_a(p0), .pulse_b(p1),
      .hi_a(hi0), .per_a(per0), .hi_b(hi1), .per_b(per1), .gap(gap));

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // -------------------------------------------------------------
   // checking and closing
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // -------------------------------------------------------------
   // bus master
   // -------------------------------------------------------------
   // each task starts on a fresh edge so no strobe is driven twice in one step
   // handshake outputs are read before the edge, where they are settled
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int         n;
      logic [2:0] ok;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         ok = {awready, wready, bvalid};
         br = bresp;
         @(posedge aclk);
         n++;
         if (ok[2]) awvalid <= 1'b0;
         if (ok[1]) wvalid <= 1'b0;
      end while (!ok[0] && n < 50);
      bready <= 1'b0;
      if (n >= 50) begin
         n_mismatch++;
         end_sim();
      end
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int         n;
      logic [1:0] ok;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ok = {arready, rvalid};
         d = rdata;
         r = rresp;
         @(posedge aclk);
         n++;
         if (ok[1]) arvalid <= 1'b0;
      end while (!ok[0] && n < 50);
      rready <= 1'b0;
      if (n >= 50) begin
         n_mismatch++;
         end_sim();
      end
   endtask

   task automatic lvl(input logic v, input int n);
      repeat (n) begin
         @(negedge aclk);
         chk({31'h0000_0000, p0}, {31'h0000_0000, v});
      end
   endtask

   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hF;
      g7 = 1'b1;
      g8 = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk({28'h000_0000, pin_s, pin_f, p1, p0}, {28'h000_0000, g7, g8, 2'h0});
      for (int i = 0; i < 8; i++) begin
         axr(8'(4 * i), rd, rs);
         chk(rd, rst_tab[i]);
      end
      axr(8'h20, rd, rs);
      chk({rs, rd[29:0]}, {dapg_pkg::RESP_SLVERR, 30'h0000_0000});
      axw(8'h24, 32'h0000_0000);
      chk({30'h0000_0000, br}, {30'h0000_0000, dapg_pkg::RESP_SLVERR});
      $display("test reset values done");

      axw(dapg_pkg::ADDR_MODE_CTRL, 32'h0000_0100);
      chk({30'h0000_0000, br}, {30'h0000_0000, dapg_pkg::RESP_OKAY});
      axw(dapg_pkg::ADDR_ONTIME_ZERO, 32'h0000_0002);
      axw(dapg_pkg::ADDR_ONTIME_ONE, 32'h0000_0001);
      axw(dapg_pkg::ADDR_PERIOD_ONE, 32'h0000_0005);
      axw(dapg_pkg::ADDR_PERIOD_ZERO, 32'h0000_0003);
      repeat (60) @(posedge aclk);
      chk(per0, 32'h0000_0008);
      chk(hi0, 32'h0000_0004);
      chk(per1, 32'h0000_000C);
      chk(hi1, 32'h0000_0002);
      $display("test independent mode done");

      axw(dapg_pkg::ADDR_ONTIME_ZERO, 32'h0000_0000);
      repeat (20) @(posedge aclk);
      lvl(1'b0, 16);
      axw(dapg_pkg::ADDR_ONTIME_ZERO, 32'h0000_0009);
      repeat (20) @(posedge aclk);
      lvl(1'b1, 16);
      $display("test duty limits done");

      axw(dapg_pkg::ADDR_MODE_CTRL, 32'h0000_0000);
      axw(dapg_pkg::ADDR_ONTIME_ZERO, 32'h0000_0003);
      axw(dapg_pkg::ADDR_ONTIME_ONE, 32'h0000_0003);
      axw(dapg_pkg::ADDR_PERIOD_ONE, 32'h0000_0002);
      axw(dapg_pkg::ADDR_PERIOD_ZERO, 32'h0000_0007);
      repeat (80) @(posedge aclk);
      chk(per0, 32'h0000_0010);
      chk(per1, 32'h0000_0010);
      chk(hi1, 32'h0000_0006);
      chk(gap, 32'h0000_0006);
      $display("test offset mode done");

      g7 <= 1'b0;
      g8 <= 1'b1;
      axw(dapg_pkg::ADDR_PIN_SELECT, 32'h0000_007F);
      @(negedge aclk);
      chk({31'h0000_0000, pin_f}, {31'h0000_0000, g8});
      axw(dapg_pkg::ADDR_UPPER_IO, 32'h0000_0000);
      repeat (40) begin
         @(negedge aclk);
         chk({30'h0000_0000, pin_s, pin_f}, {30'h0000_0000, p1, p0});
      end
      $display("test pin select done");
      end_sim();
   end
endmodule
